// File: rtl/pphp_defs.vh
// pphp_defs.vh: timing counts and field positions for the parallel host port
// assumes a 100 MHz core clock; included by bare name
`ifndef PPHP_DEFS_VH
`define PPHP_DEFS_VH
`define PPHP_CLK_MHZ 100
// least strobe low time, ns, rounded up to cycles
`define PPHP_STROBE_MIN_NS 500
`define PPHP_STROBE_CYC ((`PPHP_STROBE_MIN_NS * `PPHP_CLK_MHZ + 999) / 1000)
// least initialise low time, us
`define PPHP_INIT_MIN_US 50
`define PPHP_INIT_CYC (`PPHP_INIT_MIN_US * `PPHP_CLK_MHZ)
// acknowledge pulse, us
`define PPHP_ACK_US 5
`define PPHP_ACK_CYC (`PPHP_ACK_US * `PPHP_CLK_MHZ)
`define PPHP_CNT_W 13
`define PPHP_DATA_W 8
`define PPHP_FIFO_DEPTH 16
`define PPHP_FIFO_AW 4
// option-board field positions on the data lines (bit one is index 0)
`define PPHP_OPT_CHAR8_BIT 0
`define PPHP_OPT_RATE_LO_BIT 1
`define PPHP_OPT_RATE_HI_BIT 2
`define PPHP_OPT_PARITY_ODD_BIT 3
`define PPHP_OPT_PARITY_OFF_BIT 4
`define PPHP_OPT_SERIAL_IN_BIT 7
`endif

// File: rtl/pphp_fifo.v
// pphp_fifo.v: flip-flop FIFO for the print buffer
// assumes one clock; flush empties it in one cycle
`timescale 1ns/10ps
module pphp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire flush,
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem_r [0:DEPTH-1];
	reg [AW-1:0] wrPtr_r;
	reg [AW-1:0] rdPtr_r;
	reg [AW:0] count_r;
	wire doWr;
	wire doRd;
	assign inReady = (count_r != DEPTH[AW:0]);
	assign outValid = (count_r != {(AW+1){1'b0}});
	assign outData = mem_r[rdPtr_r];
	assign doWr = inValid && inReady;
	assign doRd = outValid && outReady;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_r <= {AW{1'b0}};
			rdPtr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else if (ce) begin
			if (flush) begin
				wrPtr_r <= {AW{1'b0}};
				rdPtr_r <= {AW{1'b0}};
				count_r <= {(AW+1){1'b0}};
			end else begin
				if (doWr)
					wrPtr_r <= wrPtr_r + 1'b1;
				if (doRd)
					rdPtr_r <= rdPtr_r + 1'b1;
				if (doWr && !doRd)
					count_r <= count_r + 1'b1;
				else if (doRd && !doWr)
					count_r <= count_r - 1'b1;
			end
		end
	end
	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : gEntry
			always @(posedge clk) begin
				if (ce && doWr && !flush && wrPtr_r == i[AW-1:0])
					mem_r[i] <= inData;
			end
		end
	endgenerate
endmodule // pphp_fifo

// File: rtl/pphp_host_port.v
// pphp_host_port.v: device end of the parallel host port with print buffer
// assumes pins arrive asynchronous to clk; print engine drains the buffer

`timescale 1ns/10ps
`include "pphp_defs.vh"

module pphp_host_port (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire strobeN,
	input wire [7:0] hostData,
	input wire initN,
	input wire hostSelectRequestN,
	input wire selectForceSwitch,
	output reg busy,
	output reg byteAcceptPulseN,
	output reg faultN,
	output reg paperOutFlag,
	output reg selected,
	input wire paperOut,
	input wire offLine,
	input wire errorCond,
	input wire printing,
	output wire prtValid,
	input wire prtReady,
	output wire [7:0] prtData,
	output reg initActive,
	input wire optionSelectRequestN,
	input wire serialSelect,
	output reg parityOffSelect,
	output reg parityOddSelect,
	output reg rateSelectLow,
	output reg rateSelectHigh,
	output reg char8Select,
	output reg serialIn,
	output reg serialMode
);
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_LOW = 2'd1;
	localparam [1:0] ST_PUSH = 2'd2;
	localparam [1:0] ST_ACK = 2'd3;
	localparam integer STB_CYC_I = `PPHP_STROBE_CYC;
	localparam integer INIT_CYC_I = `PPHP_INIT_CYC;
	localparam integer ACK_CYC_I = `PPHP_ACK_CYC;
	// counts cut to the counter width on purpose; all of them fit in 13 bits
	localparam [12:0] STB_CYC = STB_CYC_I[12:0];
	localparam [12:0] INIT_CYC = INIT_CYC_I[12:0];
	localparam [12:0] ACK_CYC = ACK_CYC_I[12:0];

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	// reset to the idle-high pin levels so no false strobe or init follows reset
	reg [11:0] sync1_r;
	reg [11:0] sync2_r;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_r <= 12'hfff;
			sync2_r <= 12'hfff;
		end else if (ce) begin
			sync1_r <= {strobeN, initN, hostSelectRequestN, optionSelectRequestN, hostData};
			sync2_r <= sync1_r;
		end
	end
	wire sStrobeN = sync2_r[11];
	wire sInitN = sync2_r[10];
	wire sSelReqN = sync2_r[9];
	wire sOptSelN = sync2_r[8];
	wire [7:0] sData = sync2_r[7:0];

	// switch set (default) forces selection, else host or option board must request it
	wire selReq = selectForceSwitch || (serialSelect ? !sOptSelN : !sSelReqN);

	////////////////////////////////////////////////////////////////////////
	// initialise filter: low beyond the least width resets controller
	// the counter saturates, so a long init holds the controller for as long as it lasts
	reg [12:0] initCnt_r;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			initCnt_r <= 13'h0000;
			initActive <= 1'b0;
		end else if (ce) begin
			if (sInitN) begin
				initCnt_r <= 13'h0000;
				initActive <= 1'b0;
			end else if (initCnt_r < INIT_CYC) begin
				initCnt_r <= initCnt_r + 13'h0001;
			end else begin
				initActive <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strobe handshake
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [12:0] cnt_r;
	reg [12:0] cnt_nxt;
	reg [7:0] byte_r;
	reg [7:0] byte_nxt;
	wire fifoReady;
	wire fault = paperOut || offLine || errorCond;

	// a strobe shorter than the least width falls back to idle with no byte and no ack
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		byte_nxt = byte_r;
		case (state_r)
		ST_IDLE: begin
			cnt_nxt = 13'h0000;
			if (!sStrobeN && selReq && !fault)
				state_nxt = ST_LOW;
		end
		ST_LOW: begin
			if (!sStrobeN) begin
				if (cnt_r < STB_CYC)
					cnt_nxt = cnt_r + 13'h0001;
				byte_nxt = sData;
			end else if (cnt_r >= STB_CYC) begin
				state_nxt = ST_PUSH;
			end else begin
				state_nxt = ST_IDLE;
			end
		end
		ST_PUSH: begin
			cnt_nxt = 13'h0000;
			if (fifoReady)
				state_nxt = ST_ACK;
		end
		default: begin
			if (cnt_r < ACK_CYC - 13'h0001)
				cnt_nxt = cnt_r + 13'h0001;
			else
				state_nxt = ST_IDLE;
		end
		endcase
	end

	// init holds the handshake idle; the data register keeps its last byte
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			cnt_r <= 13'h0000;
			byte_r <= 8'h00;
		end else if (ce) begin
			if (initActive) begin
				state_r <= ST_IDLE;
				cnt_r <= 13'h0000;
			end else begin
				state_r <= state_nxt;
				cnt_r <= cnt_nxt;
				byte_r <= byte_nxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// print buffer
	pphp_fifo #(
		.WIDTH(`PPHP_DATA_W),
		.DEPTH(`PPHP_FIFO_DEPTH),
		.AW(`PPHP_FIFO_AW)
	) uBuffer (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.flush(initActive),
		.inValid(state_r == ST_PUSH),
		.inReady(fifoReady),
		.inData(byte_r),
		.outValid(prtValid),
		.outReady(prtReady),
		.outData(prtData)
	);

	////////////////////////////////////////////////////////////////////////
	// status outputs and option-board decode
	// busy looks at state_nxt so it rises on the very edge a strobe is taken
	wire busyNow = initActive || state_nxt != ST_IDLE || state_r != ST_IDLE || printing || fault || !fifoReady;
	// option bits follow the synced data lines; the option board samples them itself
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b1;
			byteAcceptPulseN <= 1'b1;
			faultN <= 1'b1;
			paperOutFlag <= 1'b0;
			selected <= 1'b0;
			parityOffSelect <= 1'b0;
			parityOddSelect <= 1'b0;
			rateSelectLow <= 1'b0;
			rateSelectHigh <= 1'b0;
			char8Select <= 1'b0;
			serialIn <= 1'b1;
			serialMode <= 1'b0;
		end else if (ce) begin
			busy <= busyNow;
			byteAcceptPulseN <= !(state_nxt == ST_ACK && !initActive);
			faultN <= !fault;
			paperOutFlag <= paperOut;
			selected <= selReq && !offLine;
			serialMode <= serialSelect;
			parityOffSelect <= sData[`PPHP_OPT_PARITY_OFF_BIT];
			parityOddSelect <= sData[`PPHP_OPT_PARITY_ODD_BIT];
			rateSelectHigh <= sData[`PPHP_OPT_RATE_HI_BIT];
			rateSelectLow <= sData[`PPHP_OPT_RATE_LO_BIT];
			char8Select <= sData[`PPHP_OPT_CHAR8_BIT];
			serialIn <= sData[`PPHP_OPT_SERIAL_IN_BIT];
		end
	end
endmodule // pphp_host_port

// File: tb/pphp_host_model.sv
// pphp_host_model.sv: behavioural host driving strobe and data lines
// assumes the bench calls send and drives the remaining host pins
`timescale 1ns/10ps
module pphp_host_model (
	input wire logic clk,
	input wire logic busy,
	output logic strobeN,
	output logic [7:0] hostData
);
	initial begin
		strobeN = 1'b1;
		hostData = 8'h00;
	end
	task automatic send(input logic [7:0] d, input int lowCyc, output bit ok);
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		ok = n < 3000;
		if (ok) begin
			hostData = d;
			strobeN = 1'b0;
			repeat (lowCyc) @(negedge clk);
			strobeN = 1'b1;
			repeat (4) @(negedge clk);
			hostData = ~d;
		end
	endtask
endmodule // pphp_host_model

// File: tb/pphp_host_port_tb.sv
// pphp_host_port_tb.sv: self-checking bench for the parallel host port
// assumes the host model owns strobe and data; engine pins driven here
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; $display("[ERR] %0t %h %h", $time, a, e); end end
module pphp_host_port_tb;
	logic clk = 0, rstn = 0, initN = 1, hostSelectRequestN = 0, selectForceSwitch = 0;
	logic serialSelect = 0, optionSelectRequestN = 0, printing = 0;
	logic paperOut = 0, offLine = 0, errorCond = 0, prtReady = 0, drainOn = 1;
	logic strobeN, busy, byteAcceptPulseN, faultN, paperOutFlag, selected, prtValid, initActive;
	logic serialMode, parityOffSelect, parityOddSelect, rateSelectLow, rateSelectHigh, char8Select, serialIn;
	wire [5:0] optOut = {serialIn, parityOffSelect, parityOddSelect, rateSelectHigh, rateSelectLow, char8Select};
	logic [7:0] hostData, prtData;
	int num_errors = 0, samples_checked = 0;
	logic [7:0] expQ[$];
	always #5 clk = ~clk;
	pphp_host_model host (.clk, .busy, .strobeN, .hostData);
	pphp_host_port pphp_host_port_inst (.clk, .rstn, .ce(1'b1), .strobeN, .hostData, .initN, .hostSelectRequestN,
		.selectForceSwitch, .busy, .byteAcceptPulseN, .faultN, .paperOutFlag, .selected, .paperOut, .offLine,
		.errorCond, .printing, .prtValid, .prtReady, .prtData, .initActive, .optionSelectRequestN,
		.serialSelect, .parityOffSelect, .parityOddSelect, .rateSelectLow, .rateSelectHigh,
		.char8Select, .serialIn, .serialMode);
	always @(negedge clk) prtReady <= drainOn & $urandom % 2;
	always @(posedge clk) if (rstn && prtValid === 1'b1 && prtReady) begin
		`CHK(expQ.size() > 0, 1'b1)
		if (expQ.size()) `CHK(prtData, expQ.pop_front())
	end
	task summarize();
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic xfer(input logic [7:0] d, input int low, input bit exp);
		bit ok;
		int n;
		if (exp) expQ.push_back(d);
		host.send(d, low, ok);
		if (!ok) begin
			num_errors++;
			summarize();
		end
		n = 0;
		while (byteAcceptPulseN !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		`CHK(n < 100, exp)
		if (exp && n >= 100) summarize();
	endtask
	task automatic drained();
		int n;
		n = 0;
		while (expQ.size() && n < 3000) begin
			@(negedge clk);
			n++;
		end
		`CHK(n < 3000, 1'b1)
		if (n >= 3000) summarize();
	endtask
	initial begin
		int r;
		r = $urandom(43);
		repeat (2) @(negedge clk);
		rstn = 1;
		repeat (3) @(negedge clk);
		xfer(8'h81, 51, 1);
		for (int i = 0; i < 12; i++) xfer($urandom, 51 + $urandom % 20, 1);
		xfer(8'h5a, 20, 0);
		hostSelectRequestN = 1;
		xfer(8'ha5, 60, 0);
		selectForceSwitch = 1;
		xfer(8'h3c, 60, 1);
		for (int i = 0; i < 3; i++) begin
			{errorCond, offLine, paperOut} = 3'h1 << i;
			repeat (4) @(negedge clk);
			`CHK(faultN, 1'b0)
			`CHK(paperOutFlag, i == 0)
			`CHK(selected, i != 1)
		end
		{errorCond, offLine, paperOut} = 3'h0;
		`CHK(optOut, {hostData[7], hostData[4:0]})
		selectForceSwitch = 0;
		serialSelect = 1;
		xfer(8'h66, 55, 1);
		`CHK(serialMode, 1'b1)
		optionSelectRequestN = 1;
		xfer(8'h99, 55, 0);
		serialSelect = 0;
		selectForceSwitch = 1;
		drained();
		drainOn = 0;
		for (int i = 0; i < 16; i++) xfer($urandom, 55, 1);
		repeat (600) @(negedge clk);
		`CHK(busy, 1'b1)
		initN = 0;
		repeat (5100) @(negedge clk);
		`CHK(initActive, 1'b1)
		`CHK(prtValid, 1'b0)
		initN = 1;
		expQ.delete();
		drainOn = 1;
		xfer(8'hc3, 51, 1);
		drained();
		repeat (600) @(negedge clk);
		`CHK(busy, 1'b0)
		printing = 1;
		repeat (2) @(negedge clk);
		`CHK(busy, 1'b1)
		printing = 0;
		summarize();
	end
endmodule // pphp_host_port_tb
bind pphp_host_port pphp_props pphp_props_inst (.clk, .rstn, .busy, .byteAcceptPulseN, .faultN, .selected,
	.paperOut, .offLine, .errorCond, .initActive, .prtValid, .hostData, .char8Select, .parityOffSelect, .serialIn,
	.parityOddSelect, .rateSelectLow, .rateSelectHigh);

// File: tb/pphp_props.sv
// pphp_props.sv: port assertions for pphp_host_port
// assumes ce held high and a single clock domain
`timescale 1ns/10ps
module pphp_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic busy,
	input wire logic byteAcceptPulseN,
	input wire logic faultN,
	input wire logic selected,
	input wire logic paperOut,
	input wire logic offLine,
	input wire logic errorCond,
	input wire logic initActive,
	input wire logic prtValid,
	input wire logic [7:0] hostData,
	input wire logic char8Select,
	input wire logic parityOffSelect,
	input wire logic serialIn,
	input wire logic parityOddSelect,
	input wire logic rateSelectLow,
	input wire logic rateSelectHigh
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [9:0] ackCnt_r;
	// counts sampled low cycles of the acknowledge
	always @(posedge clk or negedge rstn) begin
		if (!rstn)
			ackCnt_r <= 10'h000;
		else
			ackCnt_r <= byteAcceptPulseN ? 10'h000 : ackCnt_r + 10'h001;
	end
	a_fault_out: assert property (faultN != $past(paperOut | offLine | errorCond)) else $error("fault out");
	a_ack_width: assert property ($rose(byteAcceptPulseN) |-> ackCnt_r == 10'h1f4) else $error("ack width");
	a_busy_ack: assert property (!byteAcceptPulseN |-> busy) else $error("busy in ack");
	a_busy_cond: assert property ((offLine | errorCond)[*3] |-> busy) else $error("busy in fault");
	a_ack_push: assert property ($fell(byteAcceptPulseN) |-> prtValid) else $error("ack no byte");
	a_init_flush: assert property (initActive |=> !prtValid && busy) else $error("init flush");
	a_sel_off: assert property (offLine |=> !selected) else $error("selected offline");
	a_opt_decode: assert property ((rstn && $stable(hostData))[*5] |-> char8Select == hostData[0] &&
		parityOffSelect == hostData[4] && parityOddSelect == hostData[3] && rateSelectHigh == hostData[2] &&
		rateSelectLow == hostData[1] && serialIn == hostData[7]) else $error("option decode");
	c_ack: cover property ($fell(byteAcceptPulseN));
	c_init: cover property ($rose(initActive));
	c_fault: cover property (!faultN && busy);
endmodule // pphp_props
